/* adcsq_afe_model.sv */
// Analog front end model: input mux, sample-hold and comparator.
// Assumes the bench sets one 10-bit level for each input.
`timescale 1ns/1ps
`default_nettype none
module adcsq_afe_model
   import adcsq_pkg::*;
(
   // Levels from the bench
   input  wire logic [15:0][RES_W-1:0] level,
   // Control from the block
   input  wire logic [CH_W-1:0]        analog_sel,
   input  wire logic                   sample_hold,
   input  wire logic [RES_W-1:0]       dac_code,
   // Comparator result
   output var  logic                   cmp_in
);
   logic [RES_W-1:0] held_q;  // Level caught while sampling
   always_latch
      if (sample_hold)
         held_q <= level[analog_sel];
   assign cmp_in = (held_q >= dac_code);
endmodule
`default_nettype wire

/* adcsq_edge_filter.sv */
// Trigger pin edge detector with sampled noise rejection.
// Assumes the pin is synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module adcsq_edge_filter
   import adcsq_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       ce,
   input  wire logic       rst_n,
   // Pin and settings
   input  wire logic       pin,
   input  wire logic [1:0] sclk_sel,
   input  wire logic [1:0] edge_sel,
   // Detected edge, one cycle
   output var  logic       edge_pulse
);
   logic [2:0] div_q;    // Sampling prescaler
   logic [2:0] div_mask; // Divide by 1, 2, 4 or 8
   logic       tick;
   logic [1:0] smp_q;    // Last two samples
   logic       filt_q;   // Accepted level
   logic       pulse_q;

   assign div_mask = 3'((4'h1 << sclk_sel) - 4'h1);
   assign tick     = (div_q & div_mask) == 3'h0;

   // Prescaler for the selectable sampling clock
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_q <= 3'h0;
      else if (ce)
         div_q <= div_q + 3'h1;
   end

   // Level accepted only when two samples agree; edge by setting
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smp_q   <= 2'h0;
         filt_q  <= 1'h0;
         pulse_q <= 1'h0;
      end
      else if (ce)
      begin
         pulse_q <= 1'h0;
         if (tick)
         begin
            smp_q <= {smp_q[0], pin};
            if (smp_q[1] == smp_q[0] && smp_q[0] != filt_q)
            begin
               filt_q  <= smp_q[0];
               pulse_q <= smp_q[0] ? edge_sel[0] : edge_sel[1];
            end
         end
      end
   end

   assign edge_pulse = pulse_q;
endmodule
`default_nettype wire

/* adcsq_pkg.sv */
// Shared constants for the converter sequence control block.
// Assumes a 125 MHz core clock and a 32-bit AHB-Lite register bus.
package adcsq_pkg;
   // Channel, result and register widths
   localparam int unsigned CH_W   = 4;
   localparam int unsigned RES_W  = 10;
   localparam int unsigned NRES   = 8;
   localparam int unsigned IDX_W  = 3;
   localparam int unsigned MODE_W = 16;
   localparam int unsigned TMR_W  = 12;
   // Register byte offsets
   localparam logic [7:0] OFF_MODE     = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_MASK     = 8'h08;
   localparam logic [7:0] OFF_RES_BASE = 8'h10;
   // Mode register field positions
   localparam int unsigned MODE_START_BIT = 0;
   localparam int unsigned MODE_STOP_BIT  = 1;
   localparam int unsigned MODE_HW_BIT    = 2;
   localparam int unsigned MODE_SCAN_BIT  = 3;
   localparam int unsigned MODE_CH_LSB    = 4;
   localparam int unsigned MODE_CNT_LSB   = 8;
   localparam int unsigned MODE_EDGE_LSB  = 12;
   localparam int unsigned MODE_SCLK_LSB  = 14;
   localparam logic [MODE_W-1:0] MODE_RST = 16'h1000;
   // Status register field positions
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_DONE_BIT = 1;
   localparam int unsigned STAT_CH_LSB   = 4;
   localparam int unsigned STAT_POS_LSB  = 8;
   // Trigger edge selections
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Conversion timing
   localparam int unsigned CONV_TIME_NS  = 13000;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned CONV_CYC_DEF  = CONV_TIME_NS / CLK_PERIOD_NS;
   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_STORE} adcsq_state_e;
endpackage

/* adcsq_props.sv */
// Checker on the ports of the converter sequence control top.
// Assumes the bench keeps stop writes clear of a store cycle.
`timescale 1ns/1ps
`default_nettype none
module adcsq_props
   import adcsq_pkg::*;
#(
   parameter int unsigned CONV_CYC = CONV_CYC_DEF
)
(
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            arst_n,
   // Register bus
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   input  wire logic [31:0]     hrdata,
   input  wire logic            hreadyout,
   input  wire logic            hresp,
   // Front end and completion
   input  wire logic [CH_W-1:0] analog_sel,
   input  wire logic            sample_hold,
   input  wire logic            conv_done_pulse
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic        take_w;     // Address phase taken
   logic        mode_wr_q;  // Data phase of a mode write
   logic [11:0] since_q;    // Cycles since sampling began
   assign take_w = hsel && htrans[1] && hready;
   // Mark mode write data phases
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         mode_wr_q <= 1'b0;
      else
         mode_wr_q <= take_w && hwrite && (haddr[7:0] == OFF_MODE);
   // Count from the start of sampling, saturating
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         since_q <= 12'h000;
      else if ($rose(sample_hold))
         since_q <= 12'h001;
      else if (since_q != 12'hFFF)
         since_q <= since_q + 12'h001;
   sequence s_unmapped_rd;
      take_w && !hwrite && (haddr[7:0] == 8'h0C);
   endsequence
   sequence s_stop_wr;
      mode_wr_q && hwdata[MODE_STOP_BIT];
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not OKAY");
   a_zero_wait: assert property (hreadyout == 1'b1)
      else $error("wait state inserted");
   a_unmapped_zero: assert property (s_unmapped_rd |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_stop_aborts: assert property (s_stop_wr |-> ##1 !conv_done_pulse [*8])
      else $error("result stored after stop");
   a_pulse_spaced: assert property (conv_done_pulse |=> !conv_done_pulse [*8])
      else $error("completion pulses too close");
   a_conv_time: assert property (conv_done_pulse |->
      (since_q >= CONV_CYC / 2) && (since_q <= 2 * CONV_CYC + 16))
      else $error("conversion length out of range");
   a_sel_hold: assert property (sample_hold && $past(sample_hold) |-> $stable(analog_sel))
      else $error("channel moved while sampling");
   a_steps_after: assert property ($fell(sample_hold) |-> !conv_done_pulse [*8])
      else $error("result before bit steps");
   c_done: cover property (conv_done_pulse);
endmodule
bind adcsq_top adcsq_props #(.CONV_CYC(CONV_CYC)) props_u (
   .core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .analog_sel(analog_sel),
   .sample_hold(sample_hold), .conv_done_pulse(conv_done_pulse));
`default_nettype wire

/* adcsq_sar.sv */
// Successive approximation register, one bit per step.
// Assumes step pulses are spaced wide enough for the comparator to settle.
`timescale 1ns/1ps
`default_nettype none
module adcsq_sar
   import adcsq_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic ce,
   input  wire logic rst_n,
   // Sequencer side
   adcsq_sar_if.sar  bus
);
   logic [RES_W-1:0] bit_q;    // One-hot bit under trial
   logic [RES_W-1:0] code_q;   // Trial code
   logic [RES_W-1:0] keep;     // Code with trial decided
   logic             busy_q;
   logic             done_q;
   logic [RES_W-1:0] res_q;

   // Keep the trial bit only when the input is at or above it
   assign keep = bus.cmp ? code_q : (code_q & ~bit_q);

   // Bit resolution, MSB first
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_q  <= '0;
         code_q <= '0;
         busy_q <= 1'h0;
         done_q <= 1'h0;
         res_q  <= '0;
      end
      else if (ce)
      begin
         done_q <= 1'h0;
         if (bus.abort)
            busy_q <= 1'h0;
         else if (bus.start)
         begin
            bit_q  <= {1'h1, {(RES_W-1){1'h0}}};
            code_q <= {1'h1, {(RES_W-1){1'h0}}};
            busy_q <= 1'h1;
         end
         else if (bus.step && busy_q)
         begin
            bit_q <= bit_q >> 1;
            if (bit_q[0])
            begin
               // Last bit decided
               code_q <= keep;
               res_q  <= keep;
               done_q <= 1'h1;
               busy_q <= 1'h0;
            end
            else
               code_q <= keep | (bit_q >> 1);
         end
      end
   end

   assign bus.busy   = busy_q;
   assign bus.done   = done_q;
   assign bus.code   = code_q;
   assign bus.result = res_q;
endmodule
`default_nettype wire

/* adcsq_sar_if.sv */
// Handshake between the sequencer and the approximation register.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface adcsq_sar_if
   import adcsq_pkg::*;
();
   logic             start;   // Begin a conversion
   logic             abort;   // Drop a conversion
   logic             step;    // Resolve one bit
   logic             cmp;     // Comparator: input >= trial code
   logic             busy;    // Conversion under way
   logic             done;    // Result ready, one cycle
   logic [RES_W-1:0] code;    // Trial code to the DAC
   logic [RES_W-1:0] result;  // Final result
   modport ctrl (output start, abort, step, cmp, input busy, done, code, result);
   modport sar  (input start, abort, step, cmp, output busy, done, code, result);
endinterface
`default_nettype wire

/* adcsq_tb_top.sv */
// Self-checking bench for the converter sequence control block.
// Assumes the front end model and the bound checker compile first.
`timescale 1ns/1ps
`default_nettype none
module adcsq_tb_top
   import adcsq_pkg::*;
   ;
   localparam int unsigned CYC = 44;  // Shortened conversion
   logic                   core_clk = 1'b0;
   logic                   ce = 1'b1;  // Held high
   logic                   arst_n = 1'b0;
   logic                   hsel = 1'b0;
   logic [31:0]            haddr = 32'h0000_0000;
   logic [1:0]             htrans = 2'h0;
   logic                   hwrite = 1'b0;
   logic [31:0]            hwdata = 32'h0000_0000;
   logic                   hready;
   logic [31:0]            hrdata;
   logic                   hreadyout;
   logic                   hresp;
   logic                   trig = 1'b0;  // Trigger pin
   logic [15:0][RES_W-1:0] level = '0;   // Input levels
   logic [CH_W-1:0]        analog_sel;
   logic                   sample_hold;
   logic [RES_W-1:0]       dac_code;
   logic                   cmp_in;
   logic                   irq;
   logic                   pulse;
   int                     num_errors = 0;
   int                     comparisons = 0;
   int                     pulse_cnt = 0;  // Completion pulses seen
   assign hready = hreadyout;
   always #4 core_clk = ~core_clk;
   adcsq_top #(.CONV_CYC(CYC)) dut_u (
      .core_clk(core_clk), .ce(ce), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ext_trigger_irq_input(trig), .analog_sel(analog_sel), .sample_hold(sample_hold),
      .dac_code(dac_code), .cmp_in(cmp_in), .conversion_done_irq(irq),
      .conv_done_pulse(pulse));
   adcsq_afe_model afe_u (.level(level), .analog_sel(analog_sel),
      .sample_hold(sample_hold), .dac_code(dac_code), .cmp_in(cmp_in));
   always @(posedge core_clk)
      if (pulse === 1'b1)
         pulse_cnt <= pulse_cnt + 1;
   task automatic final_report;
      $display("Counts: %0d compared, %0d mismatched", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      comparisons++;
      if (got != exp)
      begin
         num_errors++;
         $display("[ERR] %0t pulse count %0d expected %0d", $time, got, exp);
      end
   endtask
   // One single AHB transfer, zero or more wait states
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge core_clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] got;
      bus(1'b0, a, 32'h0000_0000, got);
      chk_reg(got, e);
   endtask
   task automatic wait_pulses(input int n);
      int t;
      t = pulse_cnt + n;
      for (int i = 0; i < 400 * n && pulse_cnt < t; i++) @(posedge core_clk);
      chk_cnt(pulse_cnt, t);
   endtask
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge core_clk);
      chk_reg({31'h0, irq}, {31'h0, e});
   endtask
   // Mode word: ctl holds scan, hw start, stop, start from bit 3 down
   function automatic logic [31:0] mode_w(input logic [3:0] ch, input logic [2:0] last,
      input logic [1:0] edg, input logic [3:0] ctl, input logic [1:0] sc);
      return {16'h0000, sc, edg, 1'b0, last, ch, ctl};
   endfunction
   function automatic logic [31:0] exp_res(input logic [3:0] ch);
      return {{(32 - RES_W){1'b0}}, level[ch]};
   endfunction
   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end
   // Main sequence
   initial
   begin
      logic [31:0] x;
      logic [3:0]  ch;
      logic [2:0]  last;
      logic [1:0]  edg;
      logic [1:0]  sc;
      int          c;
      x = $urandom(87);
      foreach (level[i]) level[i] = RES_W'($urandom);
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd_chk(OFF_MODE, 32'h0000_1000);
      rd_chk(OFF_MASK, 32'h0000_0000);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd_chk(8'h0C, 32'h0000_0000);
      for (int i = 0; i < 8; i++) rd_chk(8'(OFF_RES_BASE + 4 * i), 32'h0000_0000);
      $display("Test reset done");
      ch = CH_W'($urandom);
      wr(OFF_MASK, 32'h0000_0002);
      wr(OFF_MODE, mode_w(ch, 3'h0, EDGE_RISE, 4'h1, 2'h0));
      wait_pulses(1);
      irq_chk(1'b1);
      rd_chk(OFF_RES_BASE, exp_res(ch));
      wait_pulses(1);
      rd_chk(8'(OFF_RES_BASE + 4), exp_res(ch));
      wr(OFF_MASK, 32'h0000_0000);
      irq_chk(1'b0);
      wr(OFF_MODE, mode_w(ch, 3'h0, EDGE_RISE, 4'h2, 2'h0));
      wr(OFF_STATUS, 32'h0000_0002);
      wr(OFF_MASK, 32'h0000_0002);
      irq_chk(1'b0);
      $display("Test select done");
      ch = CH_W'($urandom);
      last = 3'(1 + $urandom % 7);
      wr(OFF_MODE, mode_w(ch, last, EDGE_RISE, 4'h9, 2'h0));
      wait_pulses(int'(last) + 2);
      wr(OFF_MODE, mode_w(ch, last, EDGE_RISE, 4'h2, 2'h0));
      rd_chk(OFF_STATUS, {21'h0, 3'h1, 4'(ch + 4'h1), 4'h2});
      for (int i = 0; i <= int'(last); i++)
         rd_chk(8'(OFF_RES_BASE + 4 * i), exp_res(4'(ch + i)));
      $display("Test scan done");
      wr(OFF_MODE, mode_w(ch, 3'h0, EDGE_RISE, 4'h1, 2'h0));
      repeat (10) @(posedge core_clk);
      c = pulse_cnt;
      wr(OFF_MODE, mode_w(ch, 3'h0, EDGE_RISE, 4'h3, 2'h0));
      repeat (120) @(posedge core_clk);
      chk_cnt(pulse_cnt, c);
      $display("Test stop done");
      for (int k = 1; k < 4; k++)
      begin
         edg = 2'(k);
         sc = 2'($urandom);
         wr(OFF_MODE, mode_w(ch, 3'h0, 2'h0, 4'h2, sc));
         trig <= (edg == EDGE_RISE);
         repeat (40) @(posedge core_clk);
         c = pulse_cnt;
         wr(OFF_MODE, mode_w(ch, 3'h0, edg, 4'h4, sc));
         if (edg != EDGE_BOTH)
         begin
            @(posedge core_clk);
            trig <= ~trig;
            repeat (100) @(posedge core_clk);
            chk_cnt(pulse_cnt, c);
         end
         @(posedge core_clk);
         trig <= ~trig;
         wait_pulses(1);
      end
      wr(OFF_MODE, mode_w(ch, 3'h0, 2'h0, 4'h2, 2'h0));
      $display("Test trigger done");
      final_report();
   end
endmodule
`default_nettype wire

/* adcsq_top.sv */
// Converter sequence control: start, scan/select, stop, result storage.
// Assumes an external analog mux, DAC and comparator, and one AHB-Lite master.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
   import adcsq_pkg::*;
#(
   parameter int unsigned CONV_CYC = CONV_CYC_DEF
)
(
   // Clock, enable and reset
   input  wire logic             core_clk,
   input  wire logic             ce,
   input  wire logic             arst_n,
   // AHB-Lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output var  logic [31:0]      hrdata,
   output var  logic             hreadyout,
   output var  logic             hresp,
   // Trigger pin
   input  wire logic             ext_trigger_irq_input,
   // Analog front end
   output var  logic [CH_W-1:0]  analog_sel,
   output var  logic             sample_hold,
   output var  logic [RES_W-1:0] dac_code,
   input  wire logic             cmp_in,
   // Completion
   output var  logic             conversion_done_irq,
   output var  logic             conv_done_pulse
);
   // Timing derived from the conversion length
   localparam int unsigned STEP_CYC   = CONV_CYC / (RES_W + 1);
   localparam int unsigned SAMPLE_CYC = CONV_CYC - RES_W * STEP_CYC;
   localparam logic [TMR_W-1:0] STEP_CNT   = TMR_W'(STEP_CYC - 1);
   localparam logic [TMR_W-1:0] SAMPLE_CNT = TMR_W'(SAMPLE_CYC - 1);

   // Refuse lengths the timer cannot hold
   if (CONV_CYC < 2 * (RES_W + 1) || CONV_CYC >= (1 << TMR_W))
   begin : g_bad_conv
      $error("CONV_CYC out of range");
   end

   // Reset release
   logic [1:0]         rst_sync_q;   // Two-stage release
   logic               rst_n;        // Synchronised reset
   // Bus state
   logic               wr_q;         // Write data phase pending
   logic [7:0]         wr_addr_q;    // Write address
   logic               rd_acc;       // Read address phase taken
   logic               acc;          // Any transfer taken
   logic [31:0]        hrdata_q;
   logic               hready_q;
   logic               hresp_q;
   logic [31:0]        rd_word;
   // Registers
   logic [MODE_W-1:0]  mode_q;       // converter_mode_reg settings
   logic               mask_q;       // Interrupt enable
   logic               done_q;       // Sticky completion status
   logic               irq_q;
   logic               pulse_q;
   logic [RES_W-1:0]   res_q [NRES]; // conv_result_reg_n
   // Sequencer
   adcsq_state_e       state_q;
   logic               run_q;        // Conversions requested
   logic [IDX_W-1:0]   pos_q;        // Result index / scan position
   logic [CH_W-1:0]    sel_q;        // Channel driven to the mux
   logic               sh_q;
   logic [TMR_W-1:0]   tmr_q;
   logic               tmr_zero;
   logic               start_q;
   logic               step_q;
   // Decoded controls
   logic               wr_mode;
   logic               wr_stat;
   logic               wr_mask;
   logic               sw_start;
   logic               stop_req;
   logic               start_req;
   logic               trig_edge;
   logic [CH_W-1:0]    chan;
   logic [IDX_W-1:0]   scan_last;

   adcsq_sar_if sar_bus ();

   // Reset released through two flops
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'h1};
   end
   assign rst_n = rst_sync_q[1];

   // Bus decode
   assign acc     = hsel && htrans[1] && hready;
   assign rd_acc  = acc && !hwrite;
   assign wr_mode = wr_q && wr_addr_q == OFF_MODE;
   assign wr_stat = wr_q && wr_addr_q == OFF_STATUS;
   assign wr_mask = wr_q && wr_addr_q == OFF_MASK;

   assign sw_start  = wr_mode && hwdata[MODE_START_BIT] && !hwdata[MODE_HW_BIT];
   assign stop_req  = wr_mode && hwdata[MODE_STOP_BIT];
   assign start_req = mode_q[MODE_HW_BIT] ? trig_edge : sw_start;

   // scan covers at least two channels
   assign scan_last = (mode_q[MODE_CNT_LSB +: IDX_W] == '0) ? IDX_W'(1)
                      : mode_q[MODE_CNT_LSB +: IDX_W];
   assign chan = mode_q[MODE_SCAN_BIT]
                 ? CH_W'(mode_q[MODE_CH_LSB +: CH_W] + CH_W'(pos_q))
                 : mode_q[MODE_CH_LSB +: CH_W];
   assign tmr_zero = tmr_q == '0;

   // Read data for the addressed register
   always_comb
   begin
      rd_word = '0;
      if (haddr[7:0] == OFF_MODE)
      begin
         rd_word[MODE_W-1:0]    = mode_q;
         rd_word[MODE_START_BIT] = run_q;
      end
      else if (haddr[7:0] == OFF_STATUS)
      begin
         rd_word[STAT_BUSY_BIT]            = state_q != ST_IDLE;
         rd_word[STAT_DONE_BIT]            = done_q;
         rd_word[STAT_CH_LSB +: CH_W]      = sel_q;
         rd_word[STAT_POS_LSB +: IDX_W]    = pos_q;
      end
      else if (haddr[7:0] == OFF_MASK)
         rd_word[STAT_DONE_BIT] = mask_q;
      else
      begin
         for (int i = 0; i < NRES; i++)
         begin
            if (haddr[7:0] == 8'(OFF_RES_BASE + 8'(4 * i)))
               rd_word[RES_W-1:0] = res_q[i];
         end
      end
   end

   // AHB-Lite slave: zero wait, always OKAY
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q      <= 1'h0;
         wr_addr_q <= 8'h00;
         hrdata_q  <= 32'h0000_0000;
         hready_q  <= 1'h1;
         hresp_q   <= 1'h0;
      end
      else if (ce)
      begin
         wr_q <= acc && hwrite;
         if (acc)
            wr_addr_q <= haddr[7:0];
         // Read data set up for the coming data phase
         if (rd_acc)
            hrdata_q <= rd_word;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= MODE_RST;
         mask_q <= 1'h0;
      end
      else if (ce)
      begin
         if (wr_mode)
         begin
            mode_q <= hwdata[MODE_W-1:0];
            // Start and stop are actions, never stored
            mode_q[MODE_START_BIT] <= 1'h0;
            mode_q[MODE_STOP_BIT]  <= 1'h0;
         end
         if (wr_mask)
            mask_q <= hwdata[STAT_DONE_BIT];
      end
   end

   // Run request: start sets it, stop clears it, stop wins
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         run_q <= 1'h0;
      else if (ce)
      begin
         if (stop_req)
            run_q <= 1'h0;
         else if (start_req)
            run_q <= 1'h1;
      end
   end

   // Sequencer state
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= ST_IDLE;
      else if (ce)
      begin
         if (stop_req)
            state_q <= ST_IDLE;
         else
         begin
            unique case (state_q)
               ST_IDLE:
                  if (run_q)
                     state_q <= ST_SAMPLE;
               ST_SAMPLE:
                  if (tmr_zero)
                     state_q <= ST_CONVERT;
               ST_CONVERT:
                  if (sar_bus.done)
                     state_q <= ST_STORE;
               ST_STORE:
                  state_q <= run_q ? ST_SAMPLE : ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmr_q   <= '0;
         start_q <= 1'h0;
         step_q  <= 1'h0;
      end
      else if (ce)
      begin
         start_q <= state_q == ST_SAMPLE && tmr_zero && !stop_req;
         step_q  <= state_q == ST_CONVERT && tmr_zero && !stop_req;
         if ((state_q == ST_IDLE && run_q) || state_q == ST_STORE)
            tmr_q <= SAMPLE_CNT;
         else if (tmr_zero)
            tmr_q <= STEP_CNT;
         else
            tmr_q <= tmr_q - TMR_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_q <= '0;
         sh_q  <= 1'h0;
      end
      else if (ce)
      begin
         // First sample cycle, after the scan position has moved on
         if (state_q == ST_SAMPLE && tmr_q == SAMPLE_CNT)
            sel_q <= chan;
         sh_q <= state_q == ST_SAMPLE && !stop_req && !tmr_zero;
      end
   end

   // Result index: scan position or rotating select slot
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pos_q <= '0;
      else if (ce)
      begin
         if (state_q == ST_IDLE && start_req)
            pos_q <= '0;
         else if (state_q == ST_STORE)
         begin
            // wrap after the last scanned channel
            if (mode_q[MODE_SCAN_BIT] && pos_q >= scan_last)
               pos_q <= '0;
            else
               pos_q <= pos_q + IDX_W'(1);
         end
      end
   end

   for (genvar i = 0; i < NRES; i++)
   begin : g_res
      always_ff @(posedge core_clk or negedge rst_n)
      begin
         if (!rst_n)
            res_q[i] <= '0;
         else if (ce && state_q == ST_STORE && pos_q == IDX_W'(i))
            res_q[i] <= sar_bus.result;
      end
   end

   // sticky completion, set wins over clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_q  <= 1'h0;
         irq_q   <= 1'h0;
         pulse_q <= 1'h0;
      end
      else if (ce)
      begin
         if (state_q == ST_STORE)
            done_q <= 1'h1;
         else if (wr_stat && hwdata[STAT_DONE_BIT])
            done_q <= 1'h0;
         irq_q <= done_q && mask_q;
         // one pulse per stored value for transfers
         pulse_q <= state_q == ST_STORE;
      end
   end

   assign sar_bus.start = start_q;
   assign sar_bus.step  = step_q;
   assign sar_bus.abort = stop_req;
   assign sar_bus.cmp   = cmp_in;

   adcsq_sar u_sar (
      .core_clk (core_clk),
      .ce       (ce),
      .rst_n    (rst_n),
      .bus      (sar_bus)
   );

   adcsq_edge_filter u_edge (
      .core_clk   (core_clk),
      .ce         (ce),
      .rst_n      (rst_n),
      .pin        (ext_trigger_irq_input),
      .sclk_sel   (mode_q[MODE_SCLK_LSB +: 2]),
      .edge_sel   (mode_q[MODE_EDGE_LSB +: 2]),
      .edge_pulse (trig_edge)
   );

   // Outputs straight from flops
   assign hrdata              = hrdata_q;
   assign hreadyout           = hready_q;
   assign hresp               = hresp_q;
   assign analog_sel          = sel_q;
   assign sample_hold         = sh_q;
   assign dac_code            = sar_bus.code;
   assign conversion_done_irq = irq_q;
   assign conv_done_pulse     = pulse_q;
endmodule
`default_nettype wire
